// ---- verilog/serdes_char_pkg.sv ----
/*
  Shared constants and carrier types for the ten-bit character port.
  Assumes the core clock runs at 50 MHz and the link bit clock at 30 ns.
*/
// Overview of operation
// - Capture transmit character on each rising reference edge
// - Serialize bit zero first, ascending order
// - Ten serial bits per reference period
// - Loopback low sends data; high forces outputs
// - Loopback routes transmit bits into receiver
// - Receive bus captured on both word clocks
// - Two complementary word clocks alternate characters
// - Word clocks keep running without serial input
// - True to complement rise spaced ten bits
// - Comma enable gates detection and realignment
// - Comma flag marks comma character, one slot
// - Comma flag only in complement clock slot
// - Receive latency bounded by fixed pipeline
// - Receiver locks within two microseconds
// - Misaligned comma forces boundary shift
package serdes_char_pkg;

  localparam int CHAR_W = 10;
  localparam int CNT_W = 4;
  localparam int IDLE_W = 5;

  // Bit counter value of the last bit of a character.
  localparam logic [3:0] LAST_BIT = 4'h9;

  // Comma as the seven earliest bits, earliest in bit zero.
  localparam logic [6:0] COMMA_PAT = 7'h7C;

  // Character slot codes: true word clock or its complement.
  localparam logic SLOT_TRUE = 1'b0;
  localparam logic SLOT_COMP = 1'b1;

  localparam logic [9:0] CHAR_RESET = 10'h000;

  // Timing figures in nanoseconds and derived core clock counts.
  localparam int MCLK_NS = 20;
  localparam int BIT_NS = 30;
  localparam int CHAR_NS = BIT_NS * 10;
  localparam int FREE_TICK_CYC = (CHAR_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [4:0] FREE_TICK = 5'(FREE_TICK_CYC - 1);

  typedef logic [CHAR_W-1:0] char_t;

  typedef enum logic [1:0] {
    PRES_IDLE,
    PRES_DROP,
    PRES_RISE
  } pres_state_t;

  // State clocked by the link bit clock.
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic loop_meta;
    logic loop_sync;
    logic en_meta;
    logic en_sync;
    logic rx_meta;
    logic rx_sync;
    logic tgl_meta;
    logic tgl_sync;
    logic tgl_seen;
    char_t tx_pend;
    char_t tx_shift;
    logic [CNT_W-1:0] tx_cnt;
    logic tx_bit;
    logic tx_p;
    logic tx_n;
    char_t rx_win;
    logic [CNT_W-1:0] rx_cnt;
    logic rx_slot;
    char_t out_char;
    logic out_comma;
    logic out_slot;
    logic out_tgl;
  } link_state_t;

  // State clocked by the core clock.
  typedef struct packed {
    logic ref_meta;
    logic ref_sync;
    logic ref_prev;
    char_t txd_meta;
    char_t txd_sync;
    char_t tx_hold;
    logic tx_tgl;
    logic ev_meta;
    logic ev_sync;
    logic ev_seen;
    pres_state_t state;
    logic target;
    char_t rx_char;
    logic comma;
    logic wclk;
    logic wclk_comp;
    logic [IDLE_W-1:0] idle_cnt;
  } core_state_t;

endpackage : serdes_char_pkg

// ---- verilog/tbi_serdes_char_port.sv ----
/*
  Ten-bit character port: transmit capture and serializer, receive
  deserializer with comma alignment, and word clock generation.
  Assumes mclk is the core clock, link_bit_clk a free running bit clock
  of an unrelated phase, reset synchronous to mclk, and all other pins asynchronous to both.
*/
`timescale 1ns/1ps
module tbi_serdes_char_port (
  input wire logic mclk, // Core clock, 50 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic link_bit_clk, // Serial bit clock of the link.
  input wire logic ref_clock_in, // Transmit character strobe pin.
  input wire logic [9:0] tx_char_bus, // Transmit character.
  input wire logic loopback_select, // High selects internal loopback.
  input wire logic comma_sync_enable, // High enables comma alignment.
  input wire logic rx_serial_in, // Serial receive data pin.
  output logic tx_serial_p, // Serial transmit, true side.
  output logic tx_serial_n, // Serial transmit, inverted side.
  output logic [9:0] rx_char_bus, // Received character.
  output logic rx_word_clock, // True recovered word clock.
  output logic rx_word_clock_comp, // Complementary word clock.
  output logic comma_seen_flag // Comma present on the receive bus.
);

  serdes_char_pkg::link_state_t lk_q;
  serdes_char_pkg::link_state_t lk_d;
  serdes_char_pkg::core_state_t co_q;
  serdes_char_pkg::core_state_t co_d;

  logic rx_bit;
  serdes_char_pkg::char_t win_now;
  logic comma_hit;
  logic char_end;
  logic char_slot;
  logic rx_event;
  logic free_tick;
  logic target_high;

  // Link side: serializer, loopback and deserializer on the bit clock.
  always_comb
  begin
    lk_d = lk_q;
    lk_d.rst_meta = reset;
    lk_d.rst_sync = lk_q.rst_meta;
    lk_d.loop_meta = loopback_select;
    lk_d.loop_sync = lk_q.loop_meta;
    lk_d.en_meta = comma_sync_enable;
    lk_d.en_sync = lk_q.en_meta;
    lk_d.rx_meta = rx_serial_in;
    lk_d.rx_sync = lk_q.rx_meta;
    lk_d.tgl_meta = co_q.tx_tgl;
    lk_d.tgl_sync = lk_q.tgl_meta;

    // A new captured character is taken once its toggle is seen; the
    // held word changed on the same edge as the toggle and has been stable since.
    if (lk_q.tgl_sync != lk_q.tgl_seen)
    begin
      lk_d.tgl_seen = lk_q.tgl_sync;
      lk_d.tx_pend = co_q.tx_hold;
    end

    // Ten bit times per character, so one character per strobe period.
    if (lk_q.tx_cnt == serdes_char_pkg::LAST_BIT)
    begin
      lk_d.tx_cnt = '0;
      lk_d.tx_bit = lk_q.tx_pend[0];
      lk_d.tx_shift = {1'b0, lk_q.tx_pend[9:1]};
    end
    else
    begin
      lk_d.tx_cnt = lk_q.tx_cnt + 4'h1;
      lk_d.tx_bit = lk_q.tx_shift[0];
      lk_d.tx_shift = {1'b0, lk_q.tx_shift[9:1]};
    end

    if (lk_q.loop_sync)
    begin
      lk_d.tx_p = 1'b1;
      lk_d.tx_n = 1'b0;
    end
    else
    begin
      lk_d.tx_p = lk_d.tx_bit;
      lk_d.tx_n = ~lk_d.tx_bit;
    end

    // Receiver: the newest bit enters at the top, so bit zero of the
    // window always holds the earliest bit of the character.
    rx_bit = lk_q.loop_sync ? lk_q.tx_bit : lk_q.rx_sync;
    win_now = {rx_bit, lk_q.rx_win[9:1]};
    comma_hit = lk_q.en_sync
      && (win_now[6:0] == serdes_char_pkg::COMMA_PAT);

    // With alignment enabled, a comma anywhere forces a character boundary here and puts that
    // character in the complement slot, which slips the word framing.
    char_end = (lk_q.rx_cnt == serdes_char_pkg::LAST_BIT)
      || comma_hit;
    char_slot = comma_hit ? serdes_char_pkg::SLOT_COMP
      : ~lk_q.rx_slot;

    lk_d.rx_win = win_now;
    if (char_end)
    begin
      lk_d.rx_cnt = '0;
      lk_d.rx_slot = char_slot;
      lk_d.out_char = win_now;
      lk_d.out_comma = comma_hit;
      lk_d.out_slot = char_slot;
      lk_d.out_tgl = ~lk_q.out_tgl;
    end
    else
    begin
      lk_d.rx_cnt = lk_q.rx_cnt + 4'h1;
    end

    if (lk_q.rst_sync)
    begin
      lk_d.tgl_seen = lk_q.tgl_sync;
      lk_d.tx_pend = serdes_char_pkg::CHAR_RESET;
      lk_d.tx_shift = serdes_char_pkg::CHAR_RESET;
      lk_d.tx_cnt = serdes_char_pkg::LAST_BIT;
      lk_d.tx_bit = 1'b0;
      lk_d.tx_p = 1'b0;
      lk_d.tx_n = 1'b1;
      lk_d.rx_win = serdes_char_pkg::CHAR_RESET;
      lk_d.rx_cnt = '0;
      lk_d.rx_slot = serdes_char_pkg::SLOT_COMP;
      lk_d.out_char = serdes_char_pkg::CHAR_RESET;
      lk_d.out_comma = 1'b0;
      lk_d.out_slot = serdes_char_pkg::SLOT_COMP;
      lk_d.out_tgl = 1'b0;
    end
  end

  always_ff @(posedge link_bit_clk)
  begin
    lk_q <= lk_d;
  end

  // Core side: transmit capture and presentation of received characters.
  always_comb
  begin
    co_d = co_q;
    co_d.ref_meta = ref_clock_in;
    co_d.ref_sync = co_q.ref_meta;
    co_d.ref_prev = co_q.ref_sync;
    co_d.txd_meta = tx_char_bus;
    co_d.txd_sync = co_q.txd_meta;
    co_d.ev_meta = lk_q.out_tgl;
    co_d.ev_sync = co_q.ev_meta;

    // Each rising strobe edge captures the character.
    if (co_q.ref_sync && !co_q.ref_prev)
    begin
      co_d.tx_hold = co_q.txd_sync;
      co_d.tx_tgl = ~co_q.tx_tgl;
    end

    rx_event = (co_q.ev_sync != co_q.ev_seen);
    // With no characters arriving the clocks keep running at about the
    // character rate from a local tick.
    free_tick = (co_q.idle_cnt == serdes_char_pkg::FREE_TICK);
    target_high = co_q.target ? co_q.wclk_comp : co_q.wclk;

    if (rx_event || free_tick)
    begin
      co_d.idle_cnt = '0;
    end
    else
    begin
      co_d.idle_cnt = co_q.idle_cnt + 5'h01;
    end

    case (co_q.state)
      serdes_char_pkg::PRES_IDLE:
      begin
        if (rx_event)
        begin
          // Data changes a full cycle before its clock rises.
          co_d.ev_seen = co_q.ev_sync;
          co_d.rx_char = lk_q.out_char;
          co_d.comma = lk_q.out_comma;
          co_d.target = lk_q.out_slot;
          co_d.state = serdes_char_pkg::PRES_RISE;
          if ((lk_q.out_slot ? co_q.wclk_comp : co_q.wclk))
          begin
            co_d.state = serdes_char_pkg::PRES_DROP;
          end
        end
        else if (free_tick)
        begin
          co_d.comma = 1'b0;
          co_d.target = co_q.wclk;
          co_d.state = serdes_char_pkg::PRES_RISE;
        end
      end
      serdes_char_pkg::PRES_DROP:
      begin
        // Same slot twice after a slip: the high clock is lowered for a
        // cycle so its next rise is clean and the other never rises.
        co_d.wclk = 1'b0;
        co_d.wclk_comp = 1'b0;
        co_d.state = serdes_char_pkg::PRES_RISE;
      end
      serdes_char_pkg::PRES_RISE:
      begin
        if (!target_high || co_q.wclk == co_q.wclk_comp)
        begin
          co_d.wclk = (co_q.target == serdes_char_pkg::SLOT_TRUE);
          co_d.wclk_comp = (co_q.target == serdes_char_pkg::SLOT_COMP);
        end
        co_d.state = serdes_char_pkg::PRES_IDLE;
      end
      default:
      begin
        co_d.state = serdes_char_pkg::PRES_IDLE;
      end
    endcase

    if (reset)
    begin
      co_d.tx_hold = serdes_char_pkg::CHAR_RESET;
      co_d.tx_tgl = 1'b0;
      // Both toggle ends restart from zero, so no stale event follows.
      co_d.ev_seen = 1'b0;
      co_d.state = serdes_char_pkg::PRES_IDLE;
      co_d.target = serdes_char_pkg::SLOT_TRUE;
      co_d.rx_char = serdes_char_pkg::CHAR_RESET;
      co_d.comma = 1'b0;
      co_d.wclk = 1'b0;
      co_d.wclk_comp = 1'b1;
      co_d.idle_cnt = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    co_q <= co_d;
  end

  assign tx_serial_p = lk_q.tx_p;
  assign tx_serial_n = lk_q.tx_n;
  assign rx_char_bus = co_q.rx_char;
  assign rx_word_clock = co_q.wclk;
  assign rx_word_clock_comp = co_q.wclk_comp;
  assign comma_seen_flag = co_q.comma;

endmodule : tbi_serdes_char_port

// ---- tb/serdes_char_properties.sv ----
/*
  Checker for the ten-bit character port.
  Assumes it is bound to the port module and sees its pins only.
*/
`timescale 1ns/1ps
module serdes_char_properties (
  input wire logic mclk, // Core clock.
  input wire logic reset, // Reset.
  input wire logic link_bit_clk, // Link clock.
  input wire logic loopback_select, // Loopback.
  input wire logic comma_sync_enable, // Comma enable.
  input wire logic tx_serial_p, // Serial out.
  input wire logic tx_serial_n, // Serial out, inverted.
  input wire logic [9:0] rx_char_bus, // Character.
  input wire logic rx_word_clock, // True clock.
  input wire logic rx_word_clock_comp, // Complement clock.
  input wire logic comma_seen_flag // Comma flag.
);
  logic [5:0] gap_q;
  logic [5:0] off_q;
  always_ff @(posedge mclk)
  begin
    gap_q <= (reset || $rose(rx_word_clock) || $rose(rx_word_clock_comp))
      ? 6'h00 : gap_q + 6'h01;
    off_q <= (reset || comma_sync_enable) ? 6'h00
      : off_q + {5'h00, off_q != 6'h3f};
  end
  sequence s_comma_in;
    $rose(comma_seen_flag);
  endsequence
  sequence s_comp_up;
    ##[1:2] (rx_word_clock_comp && !rx_word_clock);
  endsequence
  property p_comma_slot;
    @(posedge mclk) disable iff (reset) s_comma_in |-> s_comp_up;
  endproperty
  property p_comma_code;
    @(posedge mclk) disable iff (reset)
      comma_seen_flag |-> rx_char_bus[6:0] == serdes_char_pkg::COMMA_PAT;
  endproperty
  property p_comma_off;
    @(posedge mclk) disable iff (reset) off_q >= 6'h28 |-> !comma_seen_flag;
  endproperty
  property p_clk_excl;
    @(posedge mclk) disable iff (reset)
      !(rx_word_clock && rx_word_clock_comp);
  endproperty
  property p_clk_gap;
    @(posedge mclk) disable iff (reset) gap_q <= 6'h14;
  endproperty
  property p_data_setup;
    @(posedge mclk) disable iff (reset)
      $rose(rx_word_clock) || $rose(rx_word_clock_comp)
      |-> $stable(rx_char_bus);
  endproperty
  property p_tx_pair;
    @(posedge link_bit_clk) disable iff (reset) tx_serial_n == !tx_serial_p;
  endproperty
  property p_loop_hold;
    @(posedge link_bit_clk) disable iff (reset)
      loopback_select[*5] |=> tx_serial_p && !tx_serial_n;
  endproperty
  a_comma_slot: assert property (p_comma_slot)
    else $error("comma flag outside complement slot");
  a_comma_code: assert property (p_comma_code)
    else $error("comma flag without comma code");
  a_comma_off: assert property (p_comma_off)
    else $error("comma flag while disabled");
  a_clk_excl: assert property (p_clk_excl)
    else $error("both word clocks high");
  a_clk_gap: assert property (p_clk_gap)
    else $error("word clock stalled");
  a_data_setup: assert property (p_data_setup)
    else $error("data changed at word clock rise");
  a_tx_pair: assert property (p_tx_pair)
    else $error("serial pair not complementary");
  a_loop_hold: assert property (p_loop_hold)
    else $error("serial out not held in loopback");
endmodule : serdes_char_properties
bind tbi_serdes_char_port serdes_char_properties u_serdes_char_properties (
  .mclk, .reset, .link_bit_clk, .loopback_select, .comma_sync_enable,
  .tx_serial_p, .tx_serial_n, .rx_char_bus, .rx_word_clock,
  .rx_word_clock_comp, .comma_seen_flag);

// ---- tb/tbi_ctrl_model.sv ----
/*
  Controller model: alternates a comma and a data character.
  Assumes a 50 MHz mclk; one character every 15 cycles.
*/
`timescale 1ns/1ps
module tbi_ctrl_model (
  input wire logic mclk, // Core clock.
  input wire logic reset, // Holds the model idle.
  input wire logic [9:0] comma_char, // Comma character.
  input wire logic [9:0] data_char, // Data character.
  output logic ref_clock_in, // Character strobe.
  output logic [9:0] tx_char_bus // Transmit character.
);
  int phase = 0;
  logic pick = 1'b0;
  always @(posedge mclk)
  begin
    phase <= (reset || phase == 14) ? 0 : phase + 1;
    ref_clock_in <= #1 !reset && phase >= 7;
    if (phase == 2)
    begin
      tx_char_bus <= #1 pick ? data_char : comma_char;
      pick <= ~pick;
    end
  end
endmodule : tbi_ctrl_model

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the ten-bit character port.
  Assumes the controller model and the bound checker.
*/
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic link_bit_clk = 1'b0;
  logic reset = 1'b1;
  logic loopback_select = 1'b0;
  logic comma_sync_enable = 1'b0;
  logic rx_serial_in = 1'b0;
  logic ext_loop = 1'b0;
  logic prev_t = 1'b0;
  logic prev_c = 1'b0;
  logic ref_clock_in, tx_serial_p, tx_serial_n;
  logic rx_word_clock, rx_word_clock_comp, comma_seen_flag;
  logic [9:0] tx_char_bus, rx_char_bus, win;
  logic [9:0] comma_char = 10'h07c;
  logic [9:0] data_char = 10'h000;
  int fail_count = 0;
  int comparisons = 0;
  int hits = 0;
  int mode = 0;
  int seed = 32'hebea;
  initial forever #10 mclk = ~mclk;
  initial
  begin
    #7;
    forever #15 link_bit_clk = ~link_bit_clk;
  end
  tbi_ctrl_model u_tbi_ctrl_model (.mclk, .reset, .comma_char, .data_char,
    .ref_clock_in, .tx_char_bus);
  tbi_serdes_char_port u_tbi_serdes_char_port (.mclk, .reset, .link_bit_clk,
    .ref_clock_in, .tx_char_bus, .loopback_select, .comma_sync_enable,
    .rx_serial_in, .tx_serial_p, .tx_serial_n, .rx_char_bus,
    .rx_word_clock, .rx_word_clock_comp, .comma_seen_flag);
  always @(posedge link_bit_clk)
  begin
    rx_serial_in <= #1 ext_loop ? tx_serial_p : 1'($random(seed));
    win <= {tx_serial_p, win[9:1]};
    hits <= hits + int'(ext_loop && win === comma_char);
  end
  task check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  always @(negedge mclk)
  begin
    if (mode != 0 && rx_word_clock_comp && !prev_c)
    begin
      check(rx_char_bus, comma_char);
      check({9'h000, comma_seen_flag}, {9'h000, comma_sync_enable});
    end
    if (mode != 0 && rx_word_clock && !prev_t)
    begin
      check(rx_char_bus, data_char);
      check({9'h000, comma_seen_flag}, 10'h000);
    end
    prev_c = rx_word_clock_comp;
    prev_t = rx_word_clock;
  end
  task run(input logic lp, input logic en, input logic ext);
    mode = 0;
    @(posedge mclk);
    #1;
    loopback_select = lp;
    comma_sync_enable = en;
    ext_loop = ext;
    data_char = 10'($random(seed)) & 10'h1b6;
    repeat (150) @(posedge mclk);
    mode = 1;
    repeat (300) @(posedge mclk);
  endtask : run
  task end_sim;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (6) @(posedge mclk);
    #1;
    check({7'h00, rx_word_clock, rx_word_clock_comp, comma_seen_flag},
      10'h002);
    reset = 1'b0;
    run(1'b1, 1'b1, 1'b0);
    check({8'h00, tx_serial_p, tx_serial_n}, 10'h002);
    run(1'b0, 1'b1, 1'b1);
    check({9'h000, hits != 0}, 10'h001);
    run(1'b0, 1'b0, 1'b1);
    end_sim();
  end
  initial
  begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule : testbench
